// [src/rsc_pkg.sv]
// reset source combiner package: register map, field positions, delays
// assumes a 40 MHz system clock and an Avalon-MM slave with 32-bit data
//
// What this block does
// [R01] any active reset source asserts the single master system reset
// [R02] each reset type sets its own cause flag in the status register
// [R03] power-on clears all status flags except brown-out and power-on, which set
// [R04] software setting a cause flag only stores it, never resets
// [R05] bit15 trap conflict, bit14 illegal opcode or uninit register, bit9 mismatch
// [R06] bit7 external pin reset, bit6 software reset instruction
// [R07] bit4 watchdog timeout; cleared by power-save instruction or power-on
// [R08] bit3 set entering sleep, bit2 set entering idle
// [R09] bit1 by brown-out and power-on, bit0 power-on only; hardware never clears
// [R10] software may set or clear any status flag at any time
// [R11] bit5 enables watchdog; ignored, always enabled, when fuse unprogrammed
// [R12] bit8 keeps regulator active in sleep when one
// [R13] bits 13 to 10 always read zero
// [R14] switching on: power-on/brown-out use fuses, others keep current oscillator
// [R15] switching off: every reset selects clock from fuses
// [R16] reset released only after power-on and power-up timer delays expire
// [R17] oscillator and lock waits run alongside reset delay; run needs valid clock
// [R18] power-on holds reset for power-on plus start-up plus internal time
// [R19] start-up is regulator delay when regulator on, else power-up timer
// [R20] brown-out holds start-up plus internal; other resets internal time only
// [R21] crystal sources count 1024 oscillator periods; pll sources await lock
// [R22] pll and crystal after power-on or brown-out insert monitor delay
// [R23] clock monitor starts after its delay; no valid clock selects fast rc; monitor runs only after power-on or brown-out, not on a plain source
// [R24] a new reset source restarts delay timers, holding reset asserted; a longer hold already running is kept
package rsc_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int POWER_ON_DELAY_US = 10;
	localparam int REGULATOR_DELAY_US = 10;
	localparam int POWER_UP_TIMER_DELAY_MS = 64;
	localparam int INTERNAL_RESET_US = 20;
	localparam int CLOCK_MONITOR_DELAY_US = 100;
	localparam int POWER_ON_CYC = POWER_ON_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int REGULATOR_CYC = REGULATOR_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int POWER_UP_TIMER_CYC =
		POWER_UP_TIMER_DELAY_MS * (CLK_HZ / 1_000);
	localparam int INTERNAL_RESET_CYC = INTERNAL_RESET_US * (CLK_HZ / 1_000_000);
	localparam int CLOCK_MONITOR_CYC =
		CLOCK_MONITOR_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int OSC_STARTUP_PERIODS = 1024;

	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_CLOCK = 4'h8;

	localparam int BIT_POR = 0;
	localparam int BIT_BOR = 1;
	localparam int BIT_IDLE = 2;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
	localparam int BIT_SOFT_WATCHDOG_ENABLE = 5;
	localparam int BIT_SWR = 6;
	localparam int BIT_PIN_RESET_FLAG = 7;
	localparam int BIT_VREG = 8;
	localparam int BIT_CM = 9;
	localparam int BIT_IOP = 14;
	localparam int BIT_TRAP = 15;
	localparam logic [15:0] STATUS_IMPL_MASK = 16'hC3FF;
	localparam logic [15:0] STATUS_POR_VALUE = 16'h0003;
	localparam logic [2:0] OSC_FAST_RC = 3'h0;

	typedef struct packed {
		logic powerOn;
		logic brownout;
		logic pin;
		logic softwareInstr;
		logic watchdog;
		logic configMismatch;
		logic trapConflict;
		logic illegalOpcode;
	} rsc_sources_t;

	typedef struct packed {
		logic sleepEntry;
		logic idleEntry;
	} rsc_power_save_t;

	typedef enum logic [1:0] {RSC_SRC_PLAIN, RSC_SRC_PLL, RSC_SRC_XTAL,
		RSC_SRC_XTAL_PLL} rsc_osc_kind_t;
endpackage : rsc_pkg

// [src/rsc_reset_source_combiner.sv]
// reset source combiner: merges sources, records causes, times release
// assumes sources are synchronous pulses or levels on clk_sys; rst_n is
// the bench reset only and acts like a power-on
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_combiner
	import rsc_pkg::*;
#(
	parameter int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYC,
	parameter int OSC_PERIODS           = OSC_STARTUP_PERIODS
) (
	// clock, reset and the reset sources
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire rsc_sources_t      sources,
	input  wire rsc_power_save_t   powerSave,
	// fuses and board straps
	input  wire logic              watchdogFuseEnable,
	input  wire logic              regulatorEnable,
	input  wire logic              clockSwitchEnable,
	input  wire logic [2:0]        oscillatorFuseSelect,
	// oscillator side
	input  wire rsc_osc_kind_t     oscKind,
	input  wire logic              oscPeriodTick,
	input  wire logic              pllLocked,
	input  wire logic              clockValid,
	// register bus
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// to the cpu and peripherals
	output logic                   masterSystemReset,
	output logic                   clockReleased,
	output logic                   monitorActive,
	output logic [2:0]             currentOscillator,
	output logic                   watchdogEnabled,
	output logic                   regulatorSleepKeep
);

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {ST_HOLD, ST_WAIT_CLOCK, ST_MONITOR_DELAY,
		ST_RUN} rsc_state_t;

	// sequencer state and its timers
	rsc_state_t  state;
	logic [31:0] holdCount;
	logic [31:0] monCount;
	logic [10:0] oscCount;
	logic [31:0] startupCycles;
	logic [31:0] next_holdLoad;
	logic        anyReset;
	logic        powerLike;
	logic        lastPowerLike;
	logic        oscReady;

	// status register and its bus path
	logic [15:0] status;
	logic [15:0] next_status;
	logic [15:0] wdata;
	logic [31:0] readMux;
	logic        statusWrite;
	logic        ackPending;

	// last cycle of the monitor delay
	localparam logic [31:0] MON_LAST = 32'(CLOCK_MONITOR_CYC) - 32'h1;

	// rst_n counts as a power-on: fuse clock and the long delay
	assign powerLike = sources.powerOn | sources.brownout | ~rst_n;
	assign anyReset = (|sources) | ~rst_n; // R01

	////////////////////////////////////////////////////////////////////////
	// startup is the regulator delay, or the power-up timer without it;
	// the long timer only matters when the regulator is off
	always_comb begin
		if (regulatorEnable) begin
			startupCycles = 32'(REGULATOR_CYC); // R19
		end else begin
			startupCycles = 32'(POWER_UP_TIMER_CYCLES);
		end
	end

	// power resets add the startup, a true power-on its own delay too
	always_comb begin
		next_holdLoad = 32'(INTERNAL_RESET_CYC); // R20
		if (powerLike) begin
			next_holdLoad = next_holdLoad + startupCycles;
		end

		if (sources.powerOn | ~rst_n) begin
			next_holdLoad = next_holdLoad + 32'(POWER_ON_CYC); // R18
		end
	end

	////////////////////////////////////////////////////////////////////////
	// release sequencer; a fresh source reloads the timer, but a short
	// reset never cuts a longer hold that is already running
	always_ff @(posedge clk_sys) begin
		if (anyReset) begin
			state <= ST_HOLD;
			if (!rst_n || state != ST_HOLD || holdCount < next_holdLoad) begin
				holdCount <= next_holdLoad; // R24
			end
		end else begin
			case (state)
				ST_HOLD: begin
					// the count ends on one so the hold lasts its load
					if (holdCount > 32'h1) begin
						holdCount <= holdCount - 32'h1;
					end else begin
						state <= ST_WAIT_CLOCK; // R16
					end
				end

				ST_WAIT_CLOCK: begin
					if (oscReady) begin
						if (lastPowerLike && oscKind != RSC_SRC_PLAIN) begin
							state <= ST_MONITOR_DELAY; // R22
						end else begin
							state <= ST_RUN;
						end
					end
				end

				ST_MONITOR_DELAY: begin
					if (monCount >= MON_LAST) begin
						state <= ST_RUN; // R23
					end
				end

				ST_RUN: begin
					state <= ST_RUN;
				end

				default: begin
					state <= ST_HOLD;
				end
			endcase
		end
	end

	// counts only inside the monitor delay
	always_ff @(posedge clk_sys) begin
		if (anyReset || state != ST_MONITOR_DELAY) begin
			monCount <= 32'h0;
		end else begin
			monCount <= monCount + 32'h1;
		end
	end

	// remembers whether the last hold came from a power event; only
	// those holds earn the monitor delay
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lastPowerLike <= 1'b1;
		end else if (anyReset) begin
			lastPowerLike <= powerLike;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator wait counts during the reset hold, not after it; pin and
	// software resets leave a running oscillator counted as started
	always_ff @(posedge clk_sys) begin
		if (!rst_n || sources.powerOn || sources.brownout) begin
			oscCount <= 11'h0; // R17
		end else if (oscPeriodTick && oscCount < 11'(OSC_PERIODS)) begin
			oscCount <= oscCount + 11'h1; // R21
		end
	end

	// plain sources need no wait at all
	always_comb begin
		case (oscKind)
			RSC_SRC_PLAIN: begin
				oscReady = 1'b1;
			end

			RSC_SRC_PLL: begin
				oscReady = pllLocked;
			end

			RSC_SRC_XTAL: begin
				oscReady = oscCount >= 11'(OSC_PERIODS); // R21
			end

			RSC_SRC_XTAL_PLL: begin
				oscReady = pllLocked && oscCount >= 11'(OSC_PERIODS);
			end

			default: begin
				oscReady = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// reset shows in the cycle a source rises, not one edge later
	assign masterSystemReset = (state == ST_HOLD) | anyReset; // R01
	assign clockReleased = (state == ST_RUN)
		|| (state == ST_MONITOR_DELAY); // R17

	// the monitor rests while any reset is held
	assign monitorActive = (state == ST_RUN) && (oscKind != RSC_SRC_PLAIN)
		&& lastPowerLike && !anyReset;

	////////////////////////////////////////////////////////////////////////
	// clock selection: only power resets reload from fuses when switching;
	// the fast rc takes over if the monitored clock dies
	always_ff @(posedge clk_sys) begin
		if (anyReset && (powerLike || !clockSwitchEnable)) begin
			currentOscillator <= oscillatorFuseSelect; // R14 R15
		end else if (state == ST_RUN && monitorActive && !clockValid) begin
			currentOscillator <= OSC_FAST_RC; // R23
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status register; hardware sets win over a software clear
	// bus writes take effect only as the stall lifts
	assign statusWrite = avs_write && !avs_waitrequest
		&& avs_address == ADDR_STATUS;

	// byte lanes merge over the stored value
	always_comb begin
		wdata = status;
		if (avs_byteenable[0]) begin
			wdata[7:0] = avs_writedata[7:0];
		end

		if (avs_byteenable[1]) begin
			wdata[15:8] = avs_writedata[15:8];
		end
	end

	// software lands first, so an event in the same cycle keeps its flag
	always_comb begin
		next_status = status;
		if (statusWrite) begin
			next_status = wdata & STATUS_IMPL_MASK; // R04 R10 R13
		end

		if (powerSave.sleepEntry || powerSave.idleEntry) begin
			next_status[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0; // R07
		end

		// hardware sets
		if (sources.brownout) begin
			next_status[BIT_BOR] = 1'b1; // R09
		end

		if (sources.pin) begin
			next_status[BIT_PIN_RESET_FLAG] = 1'b1; // R06
		end

		if (sources.softwareInstr) begin
			next_status[BIT_SWR] = 1'b1;
		end

		if (sources.watchdog) begin
			next_status[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1; // R07
		end

		if (sources.configMismatch) begin
			next_status[BIT_CM] = 1'b1; // R05
		end

		if (sources.trapConflict) begin
			next_status[BIT_TRAP] = 1'b1;
		end

		if (sources.illegalOpcode) begin
			next_status[BIT_IOP] = 1'b1; // R02
		end

		// power-save entries
		if (powerSave.sleepEntry) begin
			next_status[BIT_SLEEP] = 1'b1; // R08
		end

		if (powerSave.idleEntry) begin
			next_status[BIT_IDLE] = 1'b1;
		end
	end

	// power-on wins over everything
	always_ff @(posedge clk_sys) begin
		if (!rst_n || sources.powerOn) begin
			status <= STATUS_POR_VALUE; // R03
		end else begin
			status <= next_status;
		end
	end

	// fuse unprogrammed forces the watchdog on
	assign watchdogEnabled = watchdogFuseEnable | status[BIT_SOFT_WATCHDOG_ENABLE]; // R11
	assign regulatorSleepKeep = status[BIT_VREG]; // R12

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait state on every access; readback is built in
	// the first cycle so it stands registered when the stall lifts
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ackPending <= 1'b0;
		end else begin
			ackPending <= (avs_read | avs_write) & ~ackPending;
		end
	end
	// combinational so the stall shows in the request's own cycle
	assign avs_waitrequest = (avs_read | avs_write) & ~ackPending;

	always_comb begin
		case (avs_address)
			ADDR_STATUS: begin
				readMux = {16'h0, status & STATUS_IMPL_MASK}; // R13
			end

			ADDR_CONTROL: begin
				readMux = {28'h0, lastPowerLike, watchdogEnabled,
					monitorActive, clockReleased};
			end

			ADDR_CLOCK: begin
				readMux = {16'h0, 1'b0, currentOscillator, 12'h0}; // R14
			end

			default: begin
				readMux = 32'h0;
			end
		endcase
	end

	// holds until the next read
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !ackPending) begin
			avs_readdata <= readMux;
		end
	end

endmodule : rsc_reset_source_combiner
`default_nettype wire

// [testbench/rsc_assertions.sv]
// checker for the reset source combiner ports
// assumes the single clk_sys domain and a synchronous rst_n
`timescale 1ns/1ps
`default_nettype none
module rsc_assertions
	import rsc_pkg::*;
(
	input wire logic         clk_sys,
	input wire logic         rst_n,
	input wire rsc_sources_t sources,
	input wire logic [3:0]   avs_address,
	input wire logic         avs_read,
	input wire logic         avs_write,
	input wire logic [31:0]  avs_writedata,
	input wire logic [3:0]   avs_byteenable,
	input wire logic [31:0]  avs_readdata,
	input wire logic         avs_waitrequest,
	input wire logic         masterSystemReset,
	input wire logic         monitorActive,
	input wire logic         watchdogFuseEnable,
	input wire logic         watchdogEnabled,
	input wire logic         regulatorSleepKeep
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////
sequence busStall;
	(avs_read || avs_write) && avs_waitrequest;
endsequence
sequence statusWrite;
	avs_write && !avs_waitrequest && avs_address == ADDR_STATUS;
endsequence
any_source_a: assert property (|sources |-> masterSystemReset)
	else $error("source active without system reset");
hold_min_a: assert property ($rose(|sources) |=> masterSystemReset[*8])
	else $error("system reset released too soon");
bus_stall_a: assert property ((avs_read || avs_write) &&
	!$past(avs_read || avs_write) |-> busStall)
	else $error("request not stalled in first cycle");
bus_answer_a: assert property (busStall |=> !avs_waitrequest)
	else $error("request not answered in second cycle");
unimpl_zero_a: assert property (avs_read && !avs_waitrequest &&
	avs_address == ADDR_STATUS |-> avs_readdata[13:10] == 4'h0)
	else $error("unimplemented status bits not zero");
no_sw_reset_a: assert property (statusWrite ##0 !masterSystemReset
	##0 !(|sources) |=> !masterSystemReset || (|sources))
	else $error("status write caused a reset");
reg_keep_a: assert property (statusWrite ##0 avs_byteenable[1] |=>
	regulatorSleepKeep == $past(avs_writedata[8]))
	else $error("regulator keep bit not stored");
wd_fuse_a: assert property (watchdogFuseEnable |-> watchdogEnabled)
	else $error("watchdog off with fuse unprogrammed");
monitor_run_a: assert property (monitorActive |-> !masterSystemReset)
	else $error("monitor active during system reset");
endmodule : rsc_assertions
bind rsc_reset_source_combiner rsc_assertions i_chk(.clk_sys(clk_sys),
	.rst_n(rst_n), .sources(sources), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.masterSystemReset(masterSystemReset), .monitorActive(monitorActive),
	.watchdogFuseEnable(watchdogFuseEnable),
	.watchdogEnabled(watchdogEnabled),
	.regulatorSleepKeep(regulatorSleepKeep));
`default_nettype wire

// [testbench/rsc_clock_source_model.sv]
// oscillator and pll model at the far side of the clock release logic
// assumes the oscillator runs slower than clk_sys
`timescale 1ns/1ps
`default_nettype none
module rsc_clock_source_model #(
	parameter int TICK_DIV    = 3,
	parameter int LOCK_CYCLES = 40
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	output logic      oscPeriodTick,
	output logic      pllLocked,
	output logic      clockValid
);
int divCount;
int lockCount;
// lock search restarts at power-on and runs beside the reset delay
always_ff @(posedge clk_sys) begin
	if (!rst_n) begin
		divCount <= 0;
		lockCount <= 0;
	end else begin
		divCount <= (divCount == TICK_DIV - 1) ? 0 : divCount + 1;
		lockCount <= (lockCount < LOCK_CYCLES) ? lockCount + 1 : lockCount;
	end
end
assign oscPeriodTick = rst_n && divCount == TICK_DIV - 1;
assign pllLocked = lockCount == LOCK_CYCLES;
assign clockValid = pllLocked;
endmodule : rsc_clock_source_model
`default_nettype wire

// [testbench/tb_reset_source_combiner.sv]
// self-checking bench for the reset source combiner
// assumes the clock source model feeds ticks, lock and clock valid
`timescale 1ns/1ps
`default_nettype none
module tb_reset_source_combiner
	import rsc_pkg::*;
;
logic clk_sys = 1'b0, rst_n = 1'b0, watchdogFuseEnable = 1'b0;
logic regulatorEnable = 1'b1, clockSwitchEnable = 1'b1;
rsc_sources_t sources = '0;
rsc_power_save_t powerSave = '0;
logic [2:0] oscillatorFuseSelect = 3'h5, currentOscillator, osc;
rsc_osc_kind_t oscKind = RSC_SRC_XTAL_PLL;
logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, clockValid;
logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
logic oscPeriodTick, pllLocked, masterSystemReset, clockReleased;
logic monitorActive, watchdogEnabled, regulatorSleepKeep;
logic [15:0] v;
int errors = 0, checks_done = 0, cyc = 0, seed = 32, n;
rsc_reset_source_combiner #(.POWER_UP_TIMER_CYCLES(100), .OSC_PERIODS(16))
	i_dut(.clk_sys(clk_sys), .rst_n(rst_n), .sources(sources),
	.powerSave(powerSave), .watchdogFuseEnable(watchdogFuseEnable),
	.regulatorEnable(regulatorEnable), .clockSwitchEnable(clockSwitchEnable),
	.oscillatorFuseSelect(oscillatorFuseSelect), .oscKind(oscKind),
	.oscPeriodTick(oscPeriodTick), .pllLocked(pllLocked),
	.clockValid(clockValid), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.masterSystemReset(masterSystemReset), .clockReleased(clockReleased),
	.monitorActive(monitorActive), .currentOscillator(currentOscillator),
	.watchdogEnabled(watchdogEnabled),
	.regulatorSleepKeep(regulatorSleepKeep));
rsc_clock_source_model i_clk(.clk_sys(clk_sys), .rst_n(rst_n),
	.oscPeriodTick(oscPeriodTick), .pllLocked(pllLocked),
	.clockValid(clockValid));
always #12.5 clk_sys = ~clk_sys;
////////////////////////////////////////////////////////////////////////////
task automatic test_done;
	$display("errors %0d checks %0d", errors, checks_done);
	if (errors == 0 && checks_done > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask : test_done
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	checks_done++;
	if (got !== exp) begin
		errors++;
		$display("mismatch %0t got %h exp %h", $time, got, exp);
	end
endtask : chk
// request held until waitrequest is seen low at an edge
task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
	@(posedge clk_sys);
	avs_address <= a;
	avs_writedata <= d;
	avs_write <= wr;
	avs_read <= !wr;
	do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
	q = avs_readdata;
	avs_write <= 1'b0;
	avs_read <= 1'b0;
endtask : bus
task automatic pulse(input logic [7:0] s);
	@(posedge clk_sys);
	sources <= rsc_sources_t'(s);
	@(posedge clk_sys);
	sources <= '0;
endtask : pulse
// edge alignment of the count is loose by two cycles either way
task automatic hold(input int exp);
	n = 0;
	while (masterSystemReset === 1'b1 && n < 9000) begin
		@(posedge clk_sys);
		n++;
	end
	chk(32'(n >= exp - 2 && n <= exp + 2), 32'h1);
endtask : hold
function automatic logic [31:0] expStatus(input int i);
	int b[7] = '{14, 15, 9, 4, 6, 7, 1};
	return 32'h1 << b[i];
endfunction : expStatus
always @(posedge clk_sys) begin
	cyc <= cyc + 1;
	if (cyc == 40000) begin
		errors++;
		test_done;
	end
end
////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (20) @(posedge clk_sys);
	rst_n <= 1'b1;
	hold(1600);
	bus(1'b0, ADDR_STATUS, 32'h0);
	chk(32'(q[15:0]), 32'h3);
	chk(32'(currentOscillator), 32'h5);
	bus(1'b0, ADDR_CLOCK, 32'h0);
	chk(q, 32'h0000_5000);
	for (int i = 0; i < 7; i++) begin
		bus(1'b1, ADDR_STATUS, 32'h0);
		osc = currentOscillator;
		oscillatorFuseSelect <= 3'($random(seed));
		pulse(8'h1 << i);
		hold(i == 6 ? 1200 : 800);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(q[15:0]), expStatus(i));
		chk(32'(currentOscillator), 32'(i == 6 ? oscillatorFuseSelect : osc));
	end
	pulse(8'h20);
	repeat (400) @(posedge clk_sys);
	pulse(8'h10);
	hold(800);
	repeat (6) begin
		v = 16'($random(seed)) | 16'h0010;
		watchdogFuseEnable <= 1'($random(seed));
		bus(1'b1, ADDR_STATUS, {16'h0, v});
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(q[15:0]), 32'(v & STATUS_IMPL_MASK));
		chk(32'(watchdogEnabled), 32'(watchdogFuseEnable | v[5]));
		chk(32'(regulatorSleepKeep), 32'(v[8]));
		powerSave <= rsc_power_save_t'(2'h1 << v[0]);
		@(posedge clk_sys);
		powerSave <= '0;
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(q[15:0]), 32'((v & 16'hC3EF) | (16'h4 << v[0])));
	end
	rst_n <= 1'b0;
	regulatorEnable <= 1'b0;
	clockSwitchEnable <= 1'b0;
	repeat (20) @(posedge clk_sys);
	rst_n <= 1'b1;
	hold(1300);
	chk(32'(currentOscillator), 32'(oscillatorFuseSelect));
	repeat (3900) @(posedge clk_sys);
	chk(32'(monitorActive), 32'h0);
	repeat (300) @(posedge clk_sys);
	chk(32'({clockReleased, monitorActive}), 32'h3);
	test_done;
end
endmodule : tb_reset_source_combiner
`default_nettype wire
